/* common/hcpm_map.svh */
`ifndef HCPM_MAP_SVH
`define HCPM_MAP_SVH

// E clock divider: last phase of the E period (4 sys_clk cycles), phases 0..3
`define HCPM_E_LAST_PH    2'h3
// phase at which the address latch strobe drops
`define HCPM_PH_AS_END    2'h1
// first phase with E high (data portion)
`define HCPM_PH_E_HIGH    2'h2
// phase in which port C read data is captured
`define HCPM_PH_SAMPLE    2'h3

// reset values
`define HCPM_RST_BYTE     8'h00
`define HCPM_RST_OE_N8    8'hff
`define HCPM_RST_OE_N6    6'h3f
`define HCPM_RST_RW       1'h1
`define HCPM_RST_E        1'h0

`endif

/* common/hcpm_pkg.sv */
package hcpm_pkg;

   // operating mode, coded as {mode_select_high, mode_select_low}
   typedef enum logic [1:0] {
      HCPM_BOOT     = 2'h0,
      HCPM_TEST     = 2'h1,
      HCPM_EXPANDED = 2'h3,
      HCPM_SINGLE   = 2'h2
   } hcpm_mode_e;

   // whole state of the pin mux
   typedef struct packed {
      hcpm_mode_e  mode;
      logic [7:0]  pb;
      logic [7:0]  pc;
      logic [7:0]  pc_oe_n;
      logic [5:0]  pd;
      logic [5:0]  pd_oe_n;
      logic        as_out;
      logic        as_oe_n;
      logic        hs_rw;
      logic        e;
      logic        rd;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic        done;
      logic [7:0]  pc_din;
      logic [7:0]  pc_latch;
      logic        latch_flag;
      logic        edge_prev;
      logic        hs_pulse;
      logic [5:0]  pd_din;
      logic [7:0]  pe;
   } hcpm_state_s;

   // true when the pins take the expansion bus assignment
   function automatic logic hcpm_is_expanded(hcpm_mode_e m);
      return m[0];
   endfunction

endpackage

/* hw/hcpm_eclk_div.sv */
`timescale 1ns/1ns
`include "hcpm_map.svh"

module hcpm_eclk_div
   import hcpm_pkg::*;
(
   input  wire logic       sys_clk_i,  // system clock
   input  wire logic       reset_i,    // sync reset, active high
   output logic      [1:0] ph_o,       // E cycle phase
   output logic            last_o      // pulse in the last phase
);

   typedef struct packed {
      logic [1:0] ph;
      logic       last;
   } hcpm_div_s;

   hcpm_div_s s_r;
   hcpm_div_s s_nxt;

   ////////////////////////////////////////////////////////////////////
   // phase counter, one step per system clock
   always_comb
   begin
      s_nxt = s_r;
      if (reset_i)
      begin
         s_nxt.ph   = 2'h0;
         s_nxt.last = 1'b0;
      end
      else
      begin
         s_nxt.ph   = (s_r.ph == `HCPM_E_LAST_PH) ? 2'h0 : s_r.ph + 2'h1;
         s_nxt.last = (s_nxt.ph == `HCPM_E_LAST_PH);
      end
   end

   // state register
   always_ff @(posedge sys_clk_i)
   begin
      s_r <= s_nxt;
   end

   assign ph_o   = s_r.ph;
   assign last_o = s_r.last;

endmodule

/* hw/hcpm_port_mux.sv */
`timescale 1ns/1ns
`include "hcpm_map.svh"


module hcpm_port_mux
   import hcpm_pkg::*;
(
   input  wire logic        sys_clk_i,          // 25 MHz clock
   input  wire logic        reset_i,            // sync reset, high
   input  wire logic        mode_select_low_i,  // mode strap, low bit
   input  wire logic        mode_select_high_i, // mode strap, high bit
   output logic      [1:0]  mode_o,             // latched mode
   output logic             e_clk_o,            // E clock pin
   // core side, parallel I/O
   input  wire logic [7:0]  pb_dout_i,          // port B output data
   input  wire logic        pb_wr_i,            // port B write pulse
   input  wire logic [7:0]  pc_dout_i,          // port C output data
   input  wire logic [7:0]  pc_ddr_i,           // port C dir, 1 = out
   output logic      [7:0]  pc_din_o,           // port C pin levels
   output logic      [7:0]  pc_latch_o,         // strobed port C data
   output logic             latch_flag_o,       // strobe seen flag
   input  wire logic        flag_clr_i,         // clear flag pulse
   input  wire logic        edge_pol_i,         // 1 = rising edge
   input  wire logic        hs_full_i,          // full handshake mode
   input  wire logic        hs_pol_i,           // 1 = strobe active hi
   // core side, expansion bus
   input  wire logic [15:0] bus_addr_i,         // cycle address
   input  wire logic        bus_rd_i,           // 1 = read cycle
   input  wire logic [7:0]  bus_wdata_i,        // write data
   output logic      [7:0]  bus_rdata_o,        // read data
   output logic             bus_done_o,         // cycle end pulse
   // core side, port D and serial units
   input  wire logic [5:0]  pd_dout_i,          // port D output data
   input  wire logic [5:0]  pd_ddr_i,           // port D dir, 1 = out
   input  wire logic        pd_wor_i,           // wired-or outputs
   output logic      [5:0]  pd_din_o,           // port D pin levels
   input  wire logic        async_serial_en_i,  // serial unit enable
   input  wire logic        async_serial_txd_i, // serial transmit data
   input  wire logic        spi_en_i,           // SPI enable
   input  wire logic        spi_master_i,       // SPI master select
   input  wire logic        spi_miso_i,         // slave out data
   input  wire logic        spi_mosi_i,         // master out data
   input  wire logic        spi_sck_i,          // master clock out
   // core side, port E
   output logic      [7:0]  pe_din_o,           // port E levels
   // pins
   output logic      [7:0]  pb_o,               // port B drive
   input  wire logic [7:0]  pc_i,               // port C pin in
   output logic      [7:0]  pc_o,               // port C drive
   output logic      [7:0]  pc_oe_n_o,          // port C enable, low
   input  wire logic [5:0]  pd_i,               // port D pin in
   output logic      [5:0]  pd_o,               // port D drive
   output logic      [5:0]  pd_oe_n_o,          // port D enable, low
   input  wire logic        edge_strobe_i,      // edge strobe input
   output logic             addr_strobe_o,      // address latch strobe
   output logic             addr_strobe_oe_n_o, // strobe A enable, low
   output logic             hs_strobe_rw_o,     // handshake strobe / R/W
   input  wire logic [7:0]  pe_i                // port E pin in
);

   hcpm_state_s s_r;
   hcpm_state_s s_nxt;
   logic [1:0]  ph;
   logic        ph_last;

   ////////////////////////////////////////////////////////////////////
   // E clock phase divider
   hcpm_eclk_div u_div
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .ph_o      (ph),
      .last_o    (ph_last)
   );

   ////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      logic [1:0] np;
      logic       exp_m;
      logic       edge_hit;
      logic       hs_lvl;
      logic [5:0] drv;
      logic [5:0] val;
      np        = 2'h0;
      exp_m     = 1'b0;
      edge_hit  = 1'b0;
      hs_lvl    = 1'b0;
      drv       = 6'h00;
      val       = 6'h00;
      s_nxt     = s_r;
      s_nxt.done = 1'b0;
      if (reset_i)
      begin
         s_nxt.mode = hcpm_mode_e'({mode_select_high_i, mode_select_low_i});
         s_nxt.pb         = `HCPM_RST_BYTE;
         s_nxt.pc         = `HCPM_RST_BYTE;
         s_nxt.pc_oe_n    = `HCPM_RST_OE_N8;
         s_nxt.pd         = 6'h00;
         s_nxt.pd_oe_n    = `HCPM_RST_OE_N6;
         s_nxt.as_out     = 1'b0;
         s_nxt.as_oe_n    = 1'b1;
         s_nxt.hs_rw      = `HCPM_RST_RW;
         s_nxt.e          = `HCPM_RST_E;
         s_nxt.rd         = `HCPM_RST_RW;
         s_nxt.wdata      = `HCPM_RST_BYTE;
         s_nxt.rdata      = `HCPM_RST_BYTE;
         s_nxt.pc_din     = `HCPM_RST_BYTE;
         s_nxt.pc_latch   = `HCPM_RST_BYTE;
         s_nxt.latch_flag = 1'b0;
         // follow the pin so release brings no false edge
         s_nxt.edge_prev  = edge_strobe_i;
         s_nxt.hs_pulse   = 1'b0;
         s_nxt.pd_din     = 6'h00;
         s_nxt.pe         = `HCPM_RST_BYTE;
      end
      else
      begin
         np    = (ph == `HCPM_E_LAST_PH) ? 2'h0 : ph + 2'h1;
         // boot and test follow single-chip and expanded pins
         exp_m = hcpm_is_expanded(s_r.mode);
         s_nxt.e = (np >= `HCPM_PH_E_HIGH);
         s_nxt.pc_din = pc_i;
         // port E sampled only, never driven
         s_nxt.pe = pe_i;
         s_nxt.pd_din = pd_i;

         if (exp_m)
         begin
            // B, C, strobe A and strobe B form the bus
            s_nxt.as_oe_n = 1'b0;
            s_nxt.hs_pulse = 1'b0;
            s_nxt.latch_flag = 1'b0;
            if (np == 2'h0)
            begin
               // every E cycle is a visible bus cycle
               // full 16-bit address, internal or not
               s_nxt.pb      = bus_addr_i[15:8];
               s_nxt.pc      = bus_addr_i[7:0];
               s_nxt.pc_oe_n = 8'h00;
               s_nxt.as_out  = 1'b1;
               s_nxt.rd      = bus_rd_i;
               s_nxt.wdata   = bus_wdata_i;
               // direction, stays low over back-to-back writes
               s_nxt.hs_rw   = bus_rd_i;
            end
            else if (np == `HCPM_PH_AS_END)
            begin
               // strobe falls while low address still stands
               s_nxt.as_out = 1'b0;
            end
            else if (np == `HCPM_PH_E_HIGH)
            begin
               // data portion, driven only on writes
               s_nxt.pc      = s_r.wdata;
               s_nxt.pc_oe_n = {8{s_r.rd}};
            end
            // read data taken at end of E high
            if (ph == `HCPM_PH_SAMPLE)
            begin
               if (s_r.rd)
               begin
                  s_nxt.rdata = pc_i;
               end
               s_nxt.done = 1'b1;
            end
         end
         else
         begin
            // no external bus, pins serve as plain I/O
            s_nxt.pb      = pb_dout_i;
            s_nxt.pc      = pc_dout_i;
            s_nxt.pc_oe_n = ~pc_ddr_i;
            s_nxt.as_out  = 1'b0;
            s_nxt.as_oe_n = 1'b1;
            s_nxt.edge_prev = edge_strobe_i;
            // selected edge of strobe A latches port C
            edge_hit = edge_pol_i ? (edge_strobe_i & ~s_r.edge_prev)
                                  : (~edge_strobe_i & s_r.edge_prev);
            if (edge_hit)
            begin
               s_nxt.pc_latch = pc_i;
            end
            // flag set wins over a clear in the same cycle
            s_nxt.latch_flag = edge_hit | (s_r.latch_flag & ~flag_clr_i);
            // strobed output: pulse from a port B write to the end of that E period
            if (pb_wr_i)
            begin
               s_nxt.hs_pulse = 1'b1;
            end
            else if (ph_last)
            begin
               s_nxt.hs_pulse = 1'b0;
            end
            // full handshake: ready while no latched data
            hs_lvl = hs_full_i ? ~s_nxt.latch_flag : s_nxt.hs_pulse;
            s_nxt.hs_rw = hs_pol_i ? hs_lvl : ~hs_lvl;
         end

         // port D mapping independent of mode
         drv = pd_ddr_i;
         val = pd_dout_i;
         // serial unit takes bits 0 and 1
         if (async_serial_en_i)
         begin
            drv[0] = 1'b0;
            drv[1] = 1'b1;
            val[1] = async_serial_txd_i;
         end
         // SPI takes bits 2 to 5, slave select always input
         if (spi_en_i)
         begin
            drv[2] = ~spi_master_i & ~pd_i[5];
            val[2] = spi_miso_i;
            drv[3] = spi_master_i;
            val[3] = spi_mosi_i;
            drv[4] = spi_master_i;
            val[4] = spi_sck_i;
            drv[5] = 1'b0;
         end
         // wired-or option releases high levels
         for (int i = 0; i < 6; i++)
         begin
            s_nxt.pd[i]      = val[i];
            s_nxt.pd_oe_n[i] = ~(drv[i] & ~(pd_wor_i & val[i]));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i)
   begin
      s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register
   assign mode_o         = s_r.mode;
   assign e_clk_o        = s_r.e;
   assign pc_din_o       = s_r.pc_din;
   assign pc_latch_o     = s_r.pc_latch;
   assign latch_flag_o   = s_r.latch_flag;
   assign bus_rdata_o    = s_r.rdata;
   assign bus_done_o     = s_r.done;
   assign pd_din_o       = s_r.pd_din;
   assign pe_din_o       = s_r.pe;
   // high address on port B in expanded modes
   assign pb_o           = s_r.pb;
   // low address or data on port C
   assign pc_o           = s_r.pc;
   assign pc_oe_n_o      = s_r.pc_oe_n;
   assign pd_o           = s_r.pd;
   assign pd_oe_n_o      = s_r.pd_oe_n;
   assign addr_strobe_o      = s_r.as_out;
   assign addr_strobe_oe_n_o = s_r.as_oe_n;
   assign hs_strobe_rw_o     = s_r.hs_rw;

endmodule

/* verif/hcpm_port_mux_sva.sv */
`timescale 1ns/1ns
module hcpm_port_mux_sva
   import hcpm_pkg::*;
(
   input  wire logic        sys_clk_i,      // clock
   input  wire logic        reset_i,        // sync reset
   input  wire logic [1:0]  mode_o,         // latched mode
   input  wire logic        e_clk_o,        // E clock
   input  wire logic [7:0]  pc_ddr_i,       // port C dir
   input  wire logic [7:0]  pc_i,           // port C pin
   input  wire logic [15:0] bus_addr_i,     // cycle address
   input  wire logic        bus_rd_i,       // read cycle
   input  wire logic [7:0]  bus_wdata_i,    // write data
   input  wire logic [7:0]  bus_rdata_o,    // read data
   input  wire logic        bus_done_o,     // cycle end
   input  wire logic [7:0]  pb_o,           // port B
   input  wire logic [7:0]  pc_o,           // port C drive
   input  wire logic [7:0]  pc_oe_n_o,      // port C enable
   input  wire logic        addr_strobe_o,      // address strobe
   input  wire logic        addr_strobe_oe_n_o, // strobe enable
   input  wire logic        hs_strobe_rw_o      // direction
);
   logic xm;
   // expansion pin assignment in force
   assign xm = mode_o[0];
   default clocking dck @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
////////////////////////////////////////
   addr_phase_a: assert property (xm && addr_strobe_o |->
      {pb_o, pc_o} == $past(bus_addr_i) && pc_oe_n_o == 8'h00
      && hs_strobe_rw_o == $past(bus_rd_i)) else $error("bad address phase");
   as_period_a: assert property (xm && addr_strobe_o |=>
      !addr_strobe_o [*3] ##1 addr_strobe_o) else $error("bad strobe period");
   wr_data_a: assert property (xm && $rose(e_clk_o)
      && !hs_strobe_rw_o |-> pc_o == $past(bus_wdata_i, 3)
      && pc_oe_n_o == 8'h00) else $error("bad write data");
   rd_dir_a: assert property (xm && e_clk_o && hs_strobe_rw_o |->
      pc_oe_n_o == 8'hff) else $error("port C driven on read");
   rw_hold_a: assert property (xm && !addr_strobe_o |->
      $stable(hs_strobe_rw_o)) else $error("direction moved mid cycle");
   rd_capture_a: assert property (xm && bus_done_o
      && $past(hs_strobe_rw_o) |-> bus_rdata_o == $past(pc_i))
      else $error("bad read data");
   single_pc_a: assert property (!xm && !$past(reset_i)
      && $stable(pc_ddr_i) |-> pc_oe_n_o == ~pc_ddr_i)
      else $error("port C direction wrong");
   as_drive_a: assert property (!$past(reset_i) |->
      addr_strobe_oe_n_o == !xm) else $error("strobe pin role wrong");
   wr_cyc_c: cover property (xm && $rose(e_clk_o) && !hs_strobe_rw_o);
   rd_cyc_c: cover property (xm && bus_done_o && $past(hs_strobe_rw_o));
   gpio_c: cover property (!xm && pc_oe_n_o != 8'hff);
endmodule

bind hcpm_port_mux hcpm_port_mux_sva u_sva (.*);

/* verif/hcpm_ext_mem.sv */
`timescale 1ns/1ns
module hcpm_ext_mem
(
   input  wire logic       sys_clk_i,     // clock
   input  wire logic       e_clk_i,       // E clock
   input  wire logic       addr_strobe_i, // address strobe
   input  wire logic       rw_i,          // 1 = read
   input  wire logic [7:0] ah_i,          // high address
   input  wire logic [7:0] ad_i,          // port C drive
   output logic      [7:0] ad_o           // device to port C
);
   logic [7:0]  mem [0:65535];
   logic [15:0] adr_r;
   logic        seen_r = 1'b0;
   logic [7:0]  last_r = 8'h5a;
   // write while E high and direction low
   always_ff @(posedge sys_clk_i)
   begin
      if (addr_strobe_i)
      begin
         adr_r  <= {ah_i, ad_i};
         seen_r <= 1'b1;
      end
      if (e_clk_i && !rw_i)
         mem[adr_r] <= ad_i;
      if (e_clk_i && rw_i)
         last_r <= ad_o;
   end
   // drive only in E high of an addressed read, else show junk
   assign ad_o = (e_clk_i && rw_i && seen_r) ? mem[adr_r] : ~last_r;
endmodule

/* verif/hcpm_port_mux_tb.sv */
`timescale 1ns/1ns
module hcpm_port_mux_tb;
   import hcpm_pkg::*;
   logic        sys_clk_i, reset_i, mode_select_low_i, mode_select_high_i;
   logic        pb_wr_i, latch_flag_o, flag_clr_i, edge_pol_i, hs_full_i;
   logic        hs_pol_i, bus_rd_i, bus_done_o, pd_wor_i, async_serial_en_i;
   logic        async_serial_txd_i, spi_en_i, spi_master_i, spi_miso_i;
   logic        spi_mosi_i, spi_sck_i, e_clk_o, edge_strobe_i, addr_strobe_o;
   logic        addr_strobe_oe_n_o, hs_strobe_rw_o, tb_strobe;
   logic [1:0]  mode_o;
   logic [7:0]  pb_dout_i, pc_dout_i, pc_ddr_i, pc_din_o, pc_latch_o, pe_i;
   logic [7:0]  bus_wdata_i, bus_rdata_o, pe_din_o, pb_o, pc_i, pc_o;
   logic [7:0]  pc_oe_n_o, tb_pc, mem_ad;
   logic [15:0] bus_addr_i;
   logic [5:0]  pd_dout_i, pd_ddr_i, pd_din_o, pd_o, pd_oe_n_o, pd_i, tb_pd;
   int          fails, check_count;

   hcpm_port_mux dut (.*);
   hcpm_ext_mem ext
   (
      .sys_clk_i (sys_clk_i),
      .e_clk_i   (e_clk_o),
      .addr_strobe_i (addr_strobe_o),
      .rw_i      (hs_strobe_rw_o),
      .ah_i      (pb_o),
      .ad_i      (pc_o),
      .ad_o      (mem_ad)
   );
   // pin levels from all drivers' enables
   assign pc_i = (pc_o & ~pc_oe_n_o)
      | ((mode_o[0] ? mem_ad : tb_pc) & pc_oe_n_o);
   assign pd_i = (pd_o & ~pd_oe_n_o) | (tb_pd & pd_oe_n_o);
   assign edge_strobe_i = addr_strobe_oe_n_o ? tb_strobe : addr_strobe_o;
////////////////////////////////////////
   task results;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task wait_done;
      for (int n = 0; n < 12; n++)
      begin
         @(posedge sys_clk_i);
         if (bus_done_o === 1'h1)
            return;
      end
      $display("MISMATCH t=%0t got=%h exp=%h", $time, bus_done_o, 1'h1);
      fails++;
      results();
   endtask
   task do_reset(input logic [1:0] m);
      @(posedge sys_clk_i);
      reset_i <= 1'h1;
      {mode_select_high_i, mode_select_low_i} <= m;
      repeat (3) @(posedge sys_clk_i);
      reset_i <= 1'h0;
      {mode_select_high_i, mode_select_low_i} <= ~m;
      cyc(3);
      chk(mode_o, m);
      chk(addr_strobe_oe_n_o, !m[0]);
   endtask
   // entered at a done edge, so the next take sees new inputs
   task bus_op(input logic [15:0] a, input logic rd,
               input logic [7:0] wd, input logic [7:0] exp);
      bus_addr_i <= a;
      bus_rd_i <= rd;
      bus_wdata_i <= wd;
      wait_done();
      wait_done();
      if (rd)
         chk(bus_rdata_o, exp);
   endtask
   task pd_case(input logic async_serial_unit, input logic spi,
                input logic [5:0] oe, input logic [5:0] lv);
      @(posedge sys_clk_i);
      async_serial_en_i <= async_serial_unit;
      spi_en_i <= spi;
      cyc(3);
      chk(pd_oe_n_o, oe);
      chk(pd_o | pd_oe_n_o, lv);
   endtask
////////////////////////////////////////
   task t_single;
      do_reset(2'h2);
      @(posedge sys_clk_i);
      pb_dout_i <= 8'ha5;
      pc_ddr_i <= 8'h0f;
      pc_dout_i <= 8'h3c;
      tb_pc <= 8'hc0;
      cyc(3);
      chk(pb_o, 8'ha5);
      chk(pc_oe_n_o, 8'hf0);
      chk(pc_din_o, 8'hcc);
      // port E read back as plain pin levels
      chk(pe_din_o, 8'h96);
      chk(hs_strobe_rw_o, 1'h1);
      @(posedge sys_clk_i);
      tb_strobe <= 1'h1;
      cyc(3);
      chk(latch_flag_o, 1'h1);
      chk(pc_latch_o, 8'hcc);
      chk(hs_strobe_rw_o, 1'h0);
      @(posedge sys_clk_i);
      tb_strobe <= 1'h0;
      tb_pc <= 8'h30;
      flag_clr_i <= 1'h1;
      @(posedge sys_clk_i);
      flag_clr_i <= 1'h0;
      cyc(3);
      chk(latch_flag_o, 1'h0);
      chk(pc_latch_o, 8'hcc);
      chk(hs_strobe_rw_o, 1'h1);
      // strobed output: one pulse after a port B write
      @(posedge sys_clk_i);
      hs_full_i <= 1'h0;
      pb_wr_i <= 1'h1;
      @(posedge sys_clk_i);
      pb_wr_i <= 1'h0;
      #1;
      chk(hs_strobe_rw_o, 1'h1);
      cyc(5);
      chk(hs_strobe_rw_o, 1'h0);
      @(posedge sys_clk_i);
      hs_full_i <= 1'h1;
   endtask
   task t_portd;
      @(posedge sys_clk_i);
      pd_ddr_i <= 6'h3f;
      pd_dout_i <= 6'h2a;
      tb_pd <= 6'h15;
      pd_case(1'h0, 1'h0, 6'h00, 6'h2a);
      pd_case(1'h1, 1'h0, 6'h01, 6'h29);
      pd_case(1'h0, 1'h1, 6'h24, 6'h36);
      chk(pd_din_o, 6'h16);
   endtask
   task t_bus;
      do_reset(2'h3);
      chk(pe_din_o, 8'h96);
      wait_done();
      bus_op(16'h1234, 1'h0, 8'ha5, 8'h00);
      bus_op(16'hfe01, 1'h0, 8'h5a, 8'h00);
      bus_op(16'h1234, 1'h1, 8'h00, 8'ha5);
      bus_op(16'hfe01, 1'h1, 8'h00, 8'h5a);
   endtask
   task t_special;
      do_reset(2'h0);
      chk(pb_o, 8'ha5);
      do_reset(2'h1);
      wait_done();
      bus_op(16'h8001, 1'h0, 8'h3c, 8'h00);
      bus_op(16'h8001, 1'h1, 8'h00, 8'h3c);
   endtask
////////////////////////////////////////
   // clock generator
   initial
   begin
      sys_clk_i = 1'h0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   // main sequence
   initial
   begin
      {mode_select_low_i, mode_select_high_i, pb_wr_i, flag_clr_i, bus_rd_i,
       pd_wor_i, async_serial_en_i, async_serial_txd_i, spi_en_i,
       spi_miso_i, spi_mosi_i, tb_strobe} = '0;
      {reset_i, edge_pol_i, hs_full_i, hs_pol_i, spi_master_i,
       spi_sck_i} = '1;
      {pb_dout_i, pc_dout_i, pc_ddr_i, bus_wdata_i, bus_addr_i, pd_dout_i,
       pd_ddr_i, tb_pc, tb_pd} = '0;
      pe_i = 8'h96;
      fails = 0;
      check_count = 0;
      t_single();
      t_portd();
      t_bus();
      t_special();
      results();
   end
endmodule
